/* File: design/lco_map.svh */
`ifndef LCO_MAP_SVH
`define LCO_MAP_SVH
// Clock rate and time bases
`define LCO_CLK_KHZ        125000
`define LCO_SS_STEP_MS     5
`define LCO_STANDBY_MS     30
`define LCO_FLAGB_UNIT_US  100
// Frequency set resistor: f_kHz * R_kohm is constant
`define LCO_FREQ_PROD      35000
`define LCO_RES_MIN_KOHM   50
`define LCO_RES_MAX_KOHM   500
// Dither sweep in percent and modulation rates in Hz
`define LCO_DITH_PCT_1     5
`define LCO_DITH_PCT_2     10
`define LCO_DITH_PCT_3     15
`define LCO_DITH_HZ_0      10000
`define LCO_DITH_HZ_1      5000
`define LCO_DITH_HZ_2      15000
`define LCO_DITH_HZ_3      22000
`define LCO_DITH_STEPS     512
// Register offsets
`define LCO_OFS_OSC        7'h00
`define LCO_OFS_SS         7'h01
`define LCO_OFS_FLAGB      7'h02
`define LCO_OFS_STATUS     7'h03
`define LCO_OFS_IRQ_STAT   7'h04
`define LCO_OFS_IRQ_MASK   7'h05
// Field positions
`define LCO_RANGE_LSB      0
`define LCO_RATE_LSB       2
`define LCO_SS_LSB         0
`define LCO_FB_EN_BIT      0
`define LCO_FB_DLY_LSB     4
`define LCO_IRQ_FAULT      0
`define LCO_IRQ_STANDBY    1
`define LCO_IRQ_SS_DONE    2
// Reset values
`define LCO_OSC_RST        8'h02
`define LCO_SS_RST         8'h00
`define LCO_FLAGB_RST      8'h01
`define LCO_MASK_RST       8'h00
`endif

/* File: design/lco_osc.sv */
`timescale 1ns/1ps
`include "lco_map.svh"
module lco_osc (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       enable,
    input  wire logic [9:0] res_kohm,
    input  wire logic [1:0] range_sel,
    input  wire logic [1:0] rate_sel,
    output logic            sw_clk,
    output logic            sw_tick
);
    lco_pkg::lco_osc_st_s st_q, st_d;
    int base, pct, span, tri8, offs, pre_max;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        base = int'(res_kohm) * `LCO_CLK_KHZ / `LCO_FREQ_PROD;
        case (st_q.range)
            2'b01:   pct = `LCO_DITH_PCT_1;
            2'b10:   pct = `LCO_DITH_PCT_2;
            2'b11:   pct = `LCO_DITH_PCT_3;
            default: pct = 0;
        endcase
        case (st_q.rate)
            2'b01:   pre_max = `LCO_CLK_KHZ * 1000 / (`LCO_DITH_HZ_1 * `LCO_DITH_STEPS);
            2'b10:   pre_max = `LCO_CLK_KHZ * 1000 / (`LCO_DITH_HZ_2 * `LCO_DITH_STEPS);
            2'b11:   pre_max = `LCO_CLK_KHZ * 1000 / (`LCO_DITH_HZ_3 * `LCO_DITH_STEPS);
            default: pre_max = `LCO_CLK_KHZ * 1000 / (`LCO_DITH_HZ_0 * `LCO_DITH_STEPS);
        endcase
        span = base * pct / 100;
        tri8 = st_q.pos[8] ? 255 - int'(st_q.pos[7:0]) : int'(st_q.pos[7:0]);
        offs = span * tri8 / 128 - span;
        // Triangle sweep of the period
        if (int'(st_q.pre) >= pre_max - 1) begin
            st_d.pre = 6'h00;
            st_d.pos = st_q.pos + 9'h001;
            // New selections only at a modulation period boundary
            if (st_q.pos == 9'h1ff) begin
                st_d.range = range_sel;
                st_d.rate  = rate_sel;
            end
        end else begin
            st_d.pre = st_q.pre + 6'h01;
        end
        if (!enable) begin
            st_d.cnt    = 12'h000;
            st_d.sw_clk = 1'b0;
        end else if (st_q.cnt >= st_q.period - 12'h001) begin
            // Period is reloaded only at a cycle start, so no runt pulses
            st_d.cnt    = 12'h000;
            st_d.period = 12'(base + offs);
            st_d.tick   = 1'b1;
            st_d.sw_clk = 1'b1;
        end else begin
            st_d.cnt    = st_q.cnt + 12'h001;
            st_d.sw_clk = (st_q.cnt + 12'h001) < {1'b0, st_q.period[11:1]};
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q        <= '0;
            st_q.period <= 12'h0b2;
            st_q.range  <= 2'(`LCO_OSC_RST >> `LCO_RANGE_LSB);
            st_q.rate   <= 2'(`LCO_OSC_RST >> `LCO_RATE_LSB);
        end else begin
            st_q <= st_d;
        end
    end

    assign sw_clk  = st_q.sw_clk;
    assign sw_tick = st_q.tick;
endmodule

/* File: design/lco_pkg.sv */
package lco_pkg;
    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_SOFTSTART,
        MODE_RUN,
        MODE_FAULT
    } lco_mode_e;

    typedef struct packed {
        logic low;
        logic high;
        logic boot;
    } lco_gate_s;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lco_req_s;

    typedef struct packed {
        logic [11:0] cnt;
        logic [11:0] period;
        logic [8:0]  pos;
        logic [5:0]  pre;
        logic [1:0]  range;
        logic [1:0]  rate;
        logic        sw_clk;
        logic        tick;
    } lco_osc_st_s;

    typedef struct packed {
        logic       sck;
        logic [4:0] bits;
        logic [15:0] sh;
        logic [7:0] dout;
        logic       sdo;
        logic       oe;
        logic       rdw;
        lco_req_s   req;
    } lco_spi_st_s;
endpackage

/* File: design/lco_spi.sv */
`timescale 1ns/1ps
module lco_spi (
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic          spi_sck,
    input  wire logic          spi_cs_n,
    input  wire logic          spi_mosi,
    input  wire logic [7:0]    rdata,
    output logic               spi_miso,
    output logic               spi_miso_oe,
    output lco_pkg::lco_req_s  req
);
    lco_pkg::lco_spi_st_s st_q, st_d;

    always_comb begin
        st_d        = st_q;
        st_d.sck    = spi_sck;
        st_d.req.wr = 1'b0;
        st_d.req.rd = 1'b0;
        st_d.rdw    = st_q.req.rd;
        if (st_q.rdw) begin
            st_d.dout = rdata;
        end
        if (spi_cs_n) begin
            st_d.bits = 5'h00;
            st_d.oe   = 1'b0;
            st_d.sdo  = 1'b0;
        end else begin
            st_d.oe = 1'b1;
            if (spi_sck && !st_q.sck) begin
                st_d.sh   = {st_q.sh[14:0], spi_mosi};
                st_d.bits = st_q.bits + 5'h01;
                if (st_q.bits == 5'h07) begin
                    st_d.req.addr = {st_q.sh[5:0], spi_mosi};
                    st_d.req.rd   = !st_q.sh[6];
                end
                if (st_q.bits == 5'h0f) begin
                    st_d.req.wdata = {st_q.sh[6:0], spi_mosi};
                    st_d.req.wr    = st_q.sh[14];
                end
            end
            if (!spi_sck && st_q.sck && st_q.bits >= 5'h08) begin
                st_d.sdo  = st_q.dout[7];
                st_d.dout = {st_q.dout[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign spi_miso    = st_q.sdo;
    assign spi_miso_oe = st_q.oe;
    assign req         = st_q.req;
endmodule

/* File: design/lco_top.sv */
// What this block does
// - Switching clock 70 to 700 kHz, set by the frequency resistor.
// - Resistor outside 50 to 500 kohm raises an open or short fault.
// - Out of reset dither is ten percent sweep at 10 kHz.
// - Range field: off, 5, 10 or 15 percent sweep.
// - Rate field: 10, 5, 15 or 22 kHz modulation.
// - Soft start field: 5, 10, 15 or 20 ms.
// - High-side switch off during soft start, synchronous afterwards.
// - Enable input high enables; short low pulses act as dimming.
// - Both fault flags are driven low on a fault.
// - Second flag can be disabled and has a programmable assert delay.
// - Bootstrap refresh runs on every switching clock cycle.
// - Serial input sampled on rising serial clock edges.
// - Serial output changes after falling serial clock edges.
// - Long low enable enters standby; short low stops switching, opens string.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "lco_map.svh"
module lco_top #(
    parameter int unsigned SS_STEP_CYCLES = `LCO_SS_STEP_MS * `LCO_CLK_KHZ,
    parameter int unsigned STANDBY_CYCLES = `LCO_STANDBY_MS * `LCO_CLK_KHZ,
    parameter int unsigned FB_UNIT_CYCLES = `LCO_FLAGB_UNIT_US * `LCO_CLK_KHZ / 1000
) (
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic [6:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata,
    input  wire logic          spi_sck,
    input  wire logic          spi_cs_n,
    input  wire logic          spi_mosi,
    output logic               spi_miso,
    output logic               spi_miso_oe,
    input  wire logic          en_pwm,
    input  wire logic [9:0]    freq_program_resistor,
    output lco_pkg::lco_gate_s gate,
    output logic               led_string_on,
    output logic               standby,
    output logic               fault_flag_a_n,
    output logic               fault_flag_a_oe,
    output logic               fault_flag_b_n,
    output logic               fault_flag_b_oe,
    output logic               irq
);
    typedef struct packed {
        logic [7:0]         osc_w;
        logic [7:0]         ss_w;
        logic [7:0]         fb_w;
        logic [7:0]         irq_stat;
        logic [7:0]         irq_mask;
        logic [7:0]         rdata;
        lco_pkg::lco_mode_e mode;
        logic [23:0]        ss_cnt;
        logic [22:0]        low_cnt;
        logic [23:0]        fb_cnt;
        lco_pkg::lco_gate_s gate;
        logic               led_on;
        logic               stby;
        logic               fa_n;
        logic               fb_n;
        logic               fa_oe;
        logic               fb_oe;
        logic               irq;
    } lco_top_st_s;

    lco_top_st_s       st_q, st_d;
    lco_pkg::lco_req_s spi_req;
    lco_pkg::lco_req_s req;
    logic              sw_clk;
    logic              sw_tick;
    logic              res_short;
    logic              res_open;
    logic              res_fault;
    logic              switching;
    logic              long_low;
    logic [7:0]        ev;
    logic [7:0]        status;
    int                ss_target;
    int                fb_target;

    lco_spi u_spi (
        .clock       (clock),
        .reset       (reset),
        .spi_sck     (spi_sck),
        .spi_cs_n    (spi_cs_n),
        .spi_mosi    (spi_mosi),
        .rdata       (st_q.rdata),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .req         (spi_req)
    );

    lco_osc u_osc (
        .clock     (clock),
        .reset     (reset),
        .enable    (switching),
        .res_kohm  (freq_program_resistor),
        .range_sel (st_q.osc_w[`LCO_RANGE_LSB +: 2]),
        .rate_sel  (st_q.osc_w[`LCO_RATE_LSB +: 2]),
        .sw_clk    (sw_clk),
        .sw_tick   (sw_tick)
    );

    // Window check on the frequency set resistor
    assign res_short = freq_program_resistor < 10'(`LCO_RES_MIN_KOHM);
    assign res_open  = freq_program_resistor > 10'(`LCO_RES_MAX_KOHM);
    assign res_fault = res_short | res_open;

    // Oscillator only runs while soft start or run is active and enable is high
    assign switching = ((st_q.mode == lco_pkg::MODE_SOFTSTART) ||
                        (st_q.mode == lco_pkg::MODE_RUN)) && en_pwm;
    assign long_low  = int'(st_q.low_cnt) >= int'(STANDBY_CYCLES) - 1;

    assign status = {2'b00,
                     ~en_pwm,
                     st_q.mode == lco_pkg::MODE_RUN,
                     st_q.mode == lco_pkg::MODE_SOFTSTART,
                     st_q.stby,
                     res_open,
                     res_short};

    // The plain port has priority; a serial access in the same cycle is lost
    always_comb begin
        if (reg_wr || reg_rd) begin
            req.addr  = reg_addr;
            req.wdata = reg_wdata;
            req.wr    = reg_wr;
            req.rd    = reg_rd;
        end else begin
            req = spi_req;
        end
    end

    always_comb begin
        st_d = st_q;
        ev   = 8'h00;
        ss_target = (int'(st_q.ss_w[`LCO_SS_LSB +: 2]) + 1) * int'(SS_STEP_CYCLES);
        fb_target = int'(st_q.fb_w[`LCO_FB_DLY_LSB +: 4]) * int'(FB_UNIT_CYCLES);

        // Low time of the enable input, saturating at the standby delay
        if (en_pwm) begin
            st_d.low_cnt = 23'h000000;
        end else if (!long_low) begin
            st_d.low_cnt = st_q.low_cnt + 23'h000001;
        end

        case (st_q.mode)
            lco_pkg::MODE_STANDBY: begin
                if (en_pwm && !res_fault) begin
                    st_d.mode   = lco_pkg::MODE_SOFTSTART;
                    st_d.ss_cnt = 24'h000000;
                end
            end
            lco_pkg::MODE_SOFTSTART: begin
                if (int'(st_q.ss_cnt) >= ss_target - 1) begin
                    st_d.mode = lco_pkg::MODE_RUN;
                    ev[`LCO_IRQ_SS_DONE] = 1'b1;
                end else begin
                    st_d.ss_cnt = st_q.ss_cnt + 24'h000001;
                end
            end
            lco_pkg::MODE_RUN: begin
                st_d.mode = lco_pkg::MODE_RUN;
            end
            lco_pkg::MODE_FAULT: begin
                if (!res_fault) begin
                    st_d.mode   = lco_pkg::MODE_SOFTSTART;
                    st_d.ss_cnt = 24'h000000;
                end
            end
            default: begin
                st_d.mode = lco_pkg::MODE_STANDBY;
            end
        endcase

        // Standby beats fault shutdown; both override the sequence above
        if (long_low && !en_pwm) begin
            st_d.mode = lco_pkg::MODE_STANDBY;
            if (st_q.mode != lco_pkg::MODE_STANDBY) begin
                ev[`LCO_IRQ_STANDBY] = 1'b1;
            end
        end else if (res_fault && st_q.mode != lco_pkg::MODE_STANDBY) begin
            st_d.mode = lco_pkg::MODE_FAULT;
            if (st_q.mode != lco_pkg::MODE_FAULT) begin
                ev[`LCO_IRQ_FAULT] = 1'b1;
            end
        end

        // Gate drive; high side held off until soft start has finished
        st_d.gate.low  = sw_clk && switching;
        st_d.gate.high = !sw_clk && switching && st_q.mode == lco_pkg::MODE_RUN;
        st_d.gate.boot = sw_tick && switching;
        st_d.led_on    = switching;
        st_d.stby      = st_q.mode == lco_pkg::MODE_STANDBY;

        // Fault flags; flag B waits out its delay before pulling low
        st_d.fa_n  = !res_fault;
        st_d.fa_oe = res_fault;
        if (!res_fault || !st_q.fb_w[`LCO_FB_EN_BIT]) begin
            st_d.fb_cnt = 24'h000000;
            st_d.fb_n   = 1'b1;
            st_d.fb_oe  = 1'b0;
        end else if (int'(st_q.fb_cnt) >= fb_target) begin
            st_d.fb_n   = 1'b0;
            st_d.fb_oe  = 1'b1;
        end else begin
            st_d.fb_cnt = st_q.fb_cnt + 24'h000001;
        end

        // Register writes
        if (req.wr) begin
            case (req.addr)
                `LCO_OFS_OSC:      st_d.osc_w    = req.wdata & 8'h0f;
                `LCO_OFS_SS:       st_d.ss_w     = req.wdata & 8'h03;
                `LCO_OFS_FLAGB:    st_d.fb_w     = req.wdata & 8'hf1;
                `LCO_OFS_IRQ_STAT: st_d.irq_stat = st_q.irq_stat & ~req.wdata;
                `LCO_OFS_IRQ_MASK: st_d.irq_mask = req.wdata & 8'h07;
                default:           st_d.osc_w    = st_q.osc_w;
            endcase
        end
        // A new event wins over a clear in the same cycle
        st_d.irq_stat = st_d.irq_stat | ev;
        st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);

        // Read data stands in the cycle after the strobe
        st_d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `LCO_OFS_OSC:      st_d.rdata = st_q.osc_w;
                `LCO_OFS_SS:       st_d.rdata = st_q.ss_w;
                `LCO_OFS_FLAGB:    st_d.rdata = st_q.fb_w;
                `LCO_OFS_STATUS:   st_d.rdata = status;
                `LCO_OFS_IRQ_STAT: st_d.rdata = st_q.irq_stat;
                `LCO_OFS_IRQ_MASK: st_d.rdata = st_q.irq_mask;
                default:           st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q          <= '0;
            st_q.osc_w    <= `LCO_OSC_RST;
            st_q.ss_w     <= `LCO_SS_RST;
            st_q.fb_w     <= `LCO_FLAGB_RST;
            st_q.irq_mask <= `LCO_MASK_RST;
            st_q.mode     <= lco_pkg::MODE_STANDBY;
            st_q.stby     <= 1'b1;
            st_q.fa_n     <= 1'b1;
            st_q.fb_n     <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata       = st_q.rdata;
    assign gate            = st_q.gate;
    assign led_string_on   = st_q.led_on;
    assign standby         = st_q.stby;
    assign fault_flag_a_n  = st_q.fa_n;
    assign fault_flag_a_oe = st_q.fa_oe;
    assign fault_flag_b_n  = st_q.fb_n;
    assign fault_flag_b_oe = st_q.fb_oe;
    assign irq             = st_q.irq;
endmodule

/* File: tb/lco_spi_host.sv */
`timescale 1ns/1ps
module lco_spi_host (
    input  wire logic clock,
    input  wire logic spi_miso,
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    // Idle levels follow the pull-downs on clock and data
    initial begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // Phases of 8 clocks, above the 3 the device needs to load read data before the first falling edge
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clock);
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (8) @(posedge clock);
            spi_mosi <= frame[i];
            repeat (8) @(posedge clock);
            spi_sck <= 1'b1;
            if (i < 8) rd[i] = spi_miso;
            repeat (8) @(posedge clock);
            spi_sck <= 1'b0;
        end
        repeat (8) @(posedge clock);
        spi_cs_n <= 1'b1;
        spi_mosi <= 1'b0;
    endtask
endmodule

/* File: tb/lco_top_sva.sv */
`timescale 1ns/1ps
module lco_top_sva #(
    parameter int unsigned STANDBY_CYCLES = 200
) (
    input wire logic               clock,
    input wire logic               reset,
    input wire logic               spi_sck,
    input wire logic               spi_cs_n,
    input wire logic               spi_miso,
    input wire logic               spi_miso_oe,
    input wire logic               en_pwm,
    input wire logic [9:0]         freq_program_resistor,
    input wire lco_pkg::lco_gate_s gate,
    input wire logic               led_string_on,
    input wire logic               standby,
    input wire logic               fault_flag_a_n,
    input wire logic               fault_flag_b_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic        res_bad;
    logic [31:0] low_q;
    logic [31:0] low_d;
    assign res_bad = freq_program_resistor < 10'd50 || freq_program_resistor > 10'd500;
    // Saturating count of low enable cycles with a healthy resistor
    always_comb begin
        low_d = (en_pwm || res_bad) ? 32'h0 : low_q + 32'(low_q < 32'hffff);
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            low_q <= 32'h0;
        end else begin
            low_q <= low_d;
        end
    end
    sequence flag_a_low_s; ##[1:3] !fault_flag_a_n; endsequence
    sequence string_open_s; ##[1:4] !led_string_on; endsequence
    flag_a_fault_a: assert property (res_bad |-> flag_a_low_s)
        else $error("flag A not low on resistor fault");
    flag_b_after_a: assert property ($fell(fault_flag_b_n) |-> !fault_flag_a_n)
        else $error("flag B fell without flag A");
    standby_entry_a: assert property (low_q == 32'(STANDBY_CYCLES + 4) |-> standby)
        else $error("no standby after long low enable");
    dim_open_a: assert property ($fell(en_pwm) |-> string_open_s)
        else $error("string not opened on low enable");
    standby_quiet_a: assert property (standby |-> gate == '0 && !led_string_on)
        else $error("switching in standby");
    miso_on_low_a: assert property ($changed(spi_miso) && !spi_cs_n && !$past(spi_cs_n)
        |-> !spi_sck)
        else $error("miso changed while serial clock high");
    miso_drive_a: assert property ((!spi_cs_n)[*3] |-> spi_miso_oe)
        else $error("miso not driven while selected");
    boot_single_a: assert property (gate.boot |=> !gate.boot)
        else $error("boot refresh longer than one cycle");
    no_overlap_a: assert property (!(gate.low && gate.high))
        else $error("both gates on");
endmodule

bind lco_top lco_top_sva #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_lco_top_sva (
    .clock, .reset, .spi_sck, .spi_cs_n, .spi_miso, .spi_miso_oe, .en_pwm,
    .freq_program_resistor, .gate, .led_string_on, .standby, .fault_flag_a_n,
    .fault_flag_b_n);

/* File: tb/lco_top_tb.sv */
`timescale 1ns/1ps
module lco_top_tb;
    logic               clock;
    logic               reset;
    logic [6:0]         reg_addr;
    logic [7:0]         reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [7:0]         reg_rdata;
    logic               spi_sck;
    logic               spi_cs_n;
    logic               spi_mosi;
    logic               spi_miso;
    logic               en_pwm;
    logic [9:0]         freq_program_resistor;
    lco_pkg::lco_gate_s gate;
    logic               led_string_on;
    logic               standby;
    logic               fault_flag_a_n;
    logic               fault_flag_a_oe;
    logic               fault_flag_b_n;
    logic               fault_flag_b_oe;
    logic               irq;
    logic [7:0]         d;
    logic               saw;
    int                 fails;
    int                 n_tests;
    int                 p;
    int                 pmin;
    int                 pmax;

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Short counts keep the run small; expectations below follow them
    lco_top #(.SS_STEP_CYCLES(400), .STANDBY_CYCLES(200), .FB_UNIT_CYCLES(10)) u_lco_top (
        .clock, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe(), .en_pwm,
        .freq_program_resistor, .gate, .led_string_on, .standby, .fault_flag_a_n,
        .fault_flag_a_oe, .fault_flag_b_n, .fault_flag_b_oe, .irq);

    lco_spi_host u_lco_spi_host (.clock, .spi_miso, .spi_sck, .spi_cs_n, .spi_mosi);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic reg_w(input logic [6:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_r(input logic [6:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(posedge clock);
        v = reg_rdata;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] exp);
        reg_r(a, d);
        check(16'(d & m), 16'(exp));
    endtask

    // Cycles between two boot refresh pulses, bounded
    task automatic boot_gap(output int n);
        for (int k = 0; k < 3000 && gate.boot !== 1'b1; k++) @(posedge clock);
        @(posedge clock);
        for (n = 1; n < 3000 && gate.boot !== 1'b1; n++) @(posedge clock);
        if (n >= 3000) begin
            fails++;
            end_sim();
        end
    endtask

    // Enable, then expect 4 steps of 400 cycles with the high side held off
    task automatic ss_run();
        saw = 1'b0;
        @(posedge clock);
        en_pwm <= 1'b1;
        repeat (1550) begin
            @(posedge clock);
            if (gate.high === 1'b1) saw = 1'b1;
        end
        check(16'(saw), 16'h0);
        rd_chk(7'h03, 8'hff, 8'h08);
        repeat (100) @(posedge clock);
        rd_chk(7'h03, 8'hff, 8'h10);
        saw = 1'b0;
        repeat (1000) begin
            @(posedge clock);
            if (gate.high === 1'b1) saw = 1'b1;
        end
        check(16'(saw), 16'h1);
        $display("soft start pass done");
    endtask

    initial begin
        reset = 1'b1;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        en_pwm = 1'b0;
        freq_program_resistor = 10'd100;
        fails = 0;
        n_tests = 0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        check(16'(standby), 16'h1);
        rd_chk(7'h00, 8'hff, 8'h02);
        rd_chk(7'h01, 8'hff, 8'h00);
        rd_chk(7'h02, 8'hff, 8'h01);
        rd_chk(7'h05, 8'hff, 8'h00);
        rd_chk(7'h7f, 8'hff, 8'h00);
        reg_w(7'h7f, 8'hff);
        reg_w(7'h05, 8'h07);
        rd_chk(7'h05, 8'hff, 8'h07);
        $display("reset values done");
        u_lco_spi_host.xfer(16'h8103, d);
        u_lco_spi_host.xfer(16'h0100, d);
        check(16'(d), 16'h0003);
        rd_chk(7'h01, 8'hff, 8'h03);
        $display("serial access done");
        ss_run();
        check(16'(irq), 16'h1);
        reg_w(7'h04, 8'h07);
        repeat (3) @(posedge clock);
        check(16'(irq), 16'h0);
        for (int i = 0; i < 16; i++) begin
            reg_w(7'h00, 8'(i));
            rd_chk(7'h00, 8'hff, 8'(i));
        end
        // New selections wait for a modulation wrap, up to 12500 cycles
        reg_w(7'h00, 8'h0c);
        repeat (13000) @(posedge clock);
        boot_gap(p);
        check(16'(p >= 355 && p <= 359), 16'h1);
        reg_w(7'h00, 8'h0f);
        repeat (6000) @(posedge clock);
        pmin = 9999;
        pmax = 0;
        for (int i = 0; i < 24; i++) begin
            boot_gap(p);
            pmin = (p < pmin) ? p : pmin;
            pmax = (p > pmax) ? p : pmax;
        end
        check(16'(pmin >= 295 && pmax <= 425 && pmax - pmin > 40), 16'h1);
        $display("dither done");
        @(posedge clock);
        en_pwm <= 1'b0;
        repeat (5) @(posedge clock);
        check(16'(led_string_on), 16'h0);
        repeat (45) @(posedge clock);
        check(16'(standby), 16'h0);
        en_pwm <= 1'b1;
        repeat (2000) @(posedge clock);
        en_pwm <= 1'b0;
        repeat (230) @(posedge clock);
        check(16'(standby), 16'h1);
        check(16'(irq), 16'h1);
        rd_chk(7'h04, 8'h02, 8'h02);
        reg_w(7'h04, 8'h07);
        ss_run();
        $display("dimming and standby done");
        reg_w(7'h02, 8'h31);
        reg_w(7'h05, 8'h00);
        @(posedge clock);
        freq_program_resistor <= 10'd20;
        repeat (4) @(posedge clock);
        check(16'({fault_flag_a_n, fault_flag_a_oe}), 16'h1);
        check(16'(irq), 16'h0);
        repeat (16) @(posedge clock);
        check(16'({fault_flag_b_n, fault_flag_b_oe}), 16'h2);
        repeat (20) @(posedge clock);
        check(16'({fault_flag_b_n, fault_flag_b_oe}), 16'h1);
        rd_chk(7'h03, 8'h03, 8'h01);
        freq_program_resistor <= 10'd600;
        rd_chk(7'h03, 8'h03, 8'h02);
        reg_w(7'h05, 8'h01);
        repeat (2) @(posedge clock);
        check(16'(irq), 16'h1);
        reg_w(7'h04, 8'h01);
        repeat (2) @(posedge clock);
        check(16'(irq), 16'h0);
        freq_program_resistor <= 10'd100;
        repeat (5) @(posedge clock);
        check(16'({fault_flag_a_n, fault_flag_a_oe}), 16'h2);
        reg_w(7'h02, 8'h00);
        freq_program_resistor <= 10'd20;
        repeat (60) @(posedge clock);
        check(16'({fault_flag_a_n, fault_flag_a_oe, fault_flag_b_n, fault_flag_b_oe}), 16'h6);
        freq_program_resistor <= 10'd100;
        $display("fault flags done");
        end_sim();
    end
endmodule
